// ===== core/drive_sup_map.svh
// Limits, field codes, reset values and timing counts for the drive supervisor.
// Assumes a 100 MHz sys_clk and a periodic supervision tick from the drive core.
`ifndef DRIVE_SUP_MAP_SVH
`define DRIVE_SUP_MAP_SVH
// Frequencies in 0.01 Hz, torque in 0.1 %, times in 0.1 s ticks
`define FREQ_UL_MIN 16'h01F4
`define FREQ_HYST 16'h0064
`define UL_FW_MIN 16'h00C8
`define UL_FW_MAX 16'h05DC
`define UL_FW_DEF 16'h0320
`define UL_ZF_MIN 16'h0064
`define UL_ZF_MAX 16'h05DC
`define UL_ZF_DEF 16'h0190
`define UL_TIME_MIN 16'h0014
`define UL_TIME_MAX 16'h1770
`define REF_MA_MIN 16'h0190
`define TEMP_LO (-16'sh000A)
`define TEMP_HI 16'sh004B
`define RESP_OFF 2'h0
`define RESP_WARN 2'h1
`define RESP_FAULT 2'h2
`define UL_MSG_CODE 8'h11
`define SYNC_STAGES 2
`endif

// ===== core/drive_sup_pkg.sv
// Types shared by the drive supervisor and its auxiliary stage slices.
// Assumes the map header supplies the numeric constants.
package drive_sup_pkg;
	typedef struct packed {
		logic [15:0] freq;
		logic [15:0] torque;
		logic dc_ok;
		logic [15:0] ref_ma;
		logic signed [15:0] temp;
	} meas_t;
	typedef struct packed {
		logic under_v;
		logic over_v;
		logic over_i;
		logic ref_flt;
		logic temp_flt;
	} fault_t;
	typedef struct packed {
		logic [15:0] start_f;
		logic [15:0] stop_f;
		logic [15:0] ref_step;
	} aux_cfg_t;
	typedef enum logic [1:0] {
		RUN_ST = 2'b00,
		SLEEP_ST = 2'b01,
		FAULT_ST = 2'b11
	} mode_t;
endpackage

// ===== core/aux_stage.sv
// One auxiliary drive stage with frequency hysteresis and start/stop delays.
// Assumes frequencies share units with the main drive and tick is one sys_clk pulse.
`timescale 1ns/1ps
`default_nettype none
`include "drive_sup_map.svh"
module aux_stage #(
	parameter int DW = 16
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic tick,
	input wire logic enable,
	input wire logic [15:0] freq,
	input wire drive_sup_pkg::aux_cfg_t cfg,
	input wire logic [DW-1:0] start_dly,
	input wire logic [DW-1:0] stop_dly,
	output logic on,
	output logic start_pulse
);
	logic [DW-1:0] cnt;
	logic want_on;
	logic want_off;
	assign want_on = enable && ({1'b0, freq} > ({1'b0, cfg.start_f} + {1'b0, `FREQ_HYST}));
	assign want_off = !enable || ({1'b0, freq} + {1'b0, `FREQ_HYST} < {1'b0, cfg.stop_f});
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			on <= 1'b0;
			cnt <= '0;
			start_pulse <= 1'b0;
		end else if (ce) begin
			start_pulse <= 1'b0;
			if (tick) begin
				// Any excursion back across the limit restarts the delay
				if (!on && want_on) begin
					if (cnt >= start_dly) begin
						on <= 1'b1;
						start_pulse <= 1'b1;
						cnt <= '0;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end else if (on && want_off) begin
					if (cnt >= stop_dly || !enable) begin
						on <= 1'b0;
						cnt <= '0;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end else begin
					cnt <= '0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== core/drive_supervisor.sv
// Drive supervision: stall frequency, underload, automatic restart, staging, sleep.
// Assumes measurements are from sys_clk logic; run_cmd_pin comes from a pin.
//
// Contract
// - Stall needs frequency strictly below stall maximum.
// - Below 5 Hz underload counter holds.
// - Minimum torque squared curve to field weakening.
// - Underload response off, warning, or stopping fault.
// - Selecting off clears underload counter.
// - Field area torque limited, default on current change.
// - Zero torque limited, default on current change.
// - Up/down counter fires response past time limit.
// - Stopped drive forces underload counter zero.
// - Restart count limited within trial time window.
// - Voltage restart waits for DC-link normal.
// - Overcurrent restart has its own enable.
// - Reference restart waits for 4 mA.
// - Temperature restart waits for normal range.
// - Auxiliary start above start frequency plus 1 Hz.
// - Auxiliary stop below stop frequency minus 1 Hz.
// - Main drive drops to stop frequency.
// - Auxiliary starts and stops are delayed.
// - Reference step added per started auxiliary.
// - Nonzero sleep level stops after delay.
// - Wake on level crossing, direction selectable.
`timescale 1ns/1ps
`default_nettype none
`include "drive_sup_map.svh"
module drive_supervisor #(
	parameter int N_AUX = 3,
	parameter int TW = 16
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic tick,
	input wire logic run_cmd_pin,
	input wire drive_sup_pkg::meas_t meas,
	input wire drive_sup_pkg::fault_t fault_in,
	input wire logic stall_cur_over,
	input wire logic [15:0] stall_freq_max,
	input wire logic [15:0] freq_max,
	input wire logic [15:0] field_weak_freq,
	input wire logic [1:0] ul_resp,
	input wire logic [15:0] ul_fw_load,
	input wire logic [15:0] ul_zf_load,
	input wire logic [15:0] ul_time,
	input wire logic motor_cur_changed,
	input wire logic [3:0] restart_tries,
	input wire logic [TW-1:0] trial_time,
	input wire logic restart_flying,
	input wire logic rs_uv_en,
	input wire logic rs_ov_en,
	input wire logic rs_oc_en,
	input wire logic rs_ref_en,
	input wire logic rs_temp_en,
	input wire logic fault_reset,
	input wire logic [1:0] aux_count,
	input wire drive_sup_pkg::aux_cfg_t [N_AUX-1:0] aux_cfg,
	input wire logic [TW-1:0] aux_start_dly,
	input wire logic [TW-1:0] aux_stop_dly,
	input wire logic [15:0] ref_in,
	input wire logic [15:0] sleep_level,
	input wire logic [TW-1:0] sleep_dly,
	input wire logic [15:0] wake_level,
	input wire logic wake_on_rise,
	output logic stall_freq_ok,
	output logic [15:0] ul_min_torque,
	output logic [15:0] ul_counter,
	output logic ul_warning,
	output logic ul_fault,
	output logic [7:0] msg_code,
	output logic run_req,
	output logic flying_start,
	output logic restart_pulse,
	output logic [N_AUX-1:0] aux_relay,
	output logic first_relay_output,
	output logic freq_drop_req,
	output logic [15:0] freq_drop_target,
	output logic [15:0] active_ref,
	output drive_sup_pkg::mode_t mode,
	output logic [3:0] restart_count
);
	logic [`SYNC_STAGES-1:0] run_sync;
	logic run_cmd;
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			run_sync <= '0;
		end else if (ce) begin
			run_sync <= {run_sync[0], run_cmd_pin};
		end
	end
	assign run_cmd = run_sync[1];

	logic running;
	assign running = run_cmd && (mode == drive_sup_pkg::RUN_ST);

	// Stall frequency: strictly below a limit clamped to fmax; no lower clamp
	logic [15:0] stall_lim;
	assign stall_lim = (stall_freq_max > freq_max) ? freq_max : stall_freq_max;
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			stall_freq_ok <= 1'b0;
		end else if (ce && tick) begin
			stall_freq_ok <= stall_cur_over && (meas.freq < stall_lim);
		end
	end

	// Load settings: clamped, and reverted to default when motor current changes
	logic [15:0] fw_set;
	logic [15:0] zf_set;
	logic cur_chg_seen;
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			fw_set <= `UL_FW_DEF;
			zf_set <= `UL_ZF_DEF;
			cur_chg_seen <= 1'b0;
		end else if (ce) begin
			cur_chg_seen <= motor_cur_changed;
			if (motor_cur_changed) begin
				fw_set <= `UL_FW_DEF;
				zf_set <= `UL_ZF_DEF;
			end else if (!cur_chg_seen) begin
				fw_set <= (ul_fw_load < `UL_FW_MIN) ? `UL_FW_MIN :
					(ul_fw_load > `UL_FW_MAX) ? `UL_FW_MAX : ul_fw_load;
				zf_set <= (ul_zf_load < `UL_ZF_MIN) ? `UL_ZF_MIN :
					(ul_zf_load > `UL_ZF_MAX) ? `UL_ZF_MAX : ul_zf_load;
			end
		end
	end

	// Squared curve: zf + (fw - zf) * (f/ffw)^2, flat above ffw
	logic [31:0] f_sq;
	logic [31:0] fw_sq;
	logic [47:0] span_prod;
	logic signed [17:0] span;
	logic signed [17:0] delta;
	logic [15:0] next_min_torque;
	always_comb begin
		f_sq = {16'h0000, meas.freq} * {16'h0000, meas.freq};
		fw_sq = {16'h0000, field_weak_freq} * {16'h0000, field_weak_freq};
		span = $signed({2'b00, fw_set}) - $signed({2'b00, zf_set});
		span_prod = (span < 0) ? ({30'h0, 18'(-span)} * {16'h0, f_sq}) : ({30'h0, 18'(span)} * {16'h0, f_sq});
		delta = (fw_sq == 32'h0) ? 18'sd0 : $signed(18'(span_prod / {16'h0, fw_sq}));
		if (meas.freq >= field_weak_freq) begin
			next_min_torque = fw_set;
		end else if (span < 0) begin
			next_min_torque = 16'(zf_set - 16'(delta));
		end else begin
			next_min_torque = 16'(zf_set + 16'(delta));
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ul_min_torque <= `UL_ZF_DEF;
		end else if (ce && tick) begin
			ul_min_torque <= next_min_torque;
		end
	end

	// Underload up/down counter in time ticks
	logic [15:0] ul_lim;
	logic ul_trip;
	assign ul_lim = (ul_time < `UL_TIME_MIN) ? `UL_TIME_MIN : (ul_time > `UL_TIME_MAX) ? `UL_TIME_MAX : ul_time;
	assign ul_trip = ul_counter > ul_lim;
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ul_counter <= '0;
		end else if (ce) begin
			if (ul_resp == `RESP_OFF) begin
				ul_counter <= '0;
			end else if (!running) begin
				ul_counter <= '0;
			end else if (tick && meas.freq >= `FREQ_UL_MIN) begin
				if (meas.torque < ul_min_torque) begin
					if (!ul_trip) begin
						ul_counter <= ul_counter + 16'h0001;
					end
				end else if (ul_counter != 16'h0000) begin
					ul_counter <= ul_counter - 16'h0001;
				end
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ul_warning <= 1'b0;
		end else if (ce) begin
			ul_warning <= ul_trip && (ul_resp == `RESP_WARN);
		end
	end
	logic ul_fault_set;
	assign ul_fault_set = ul_trip && (ul_resp == `RESP_FAULT) && running;
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			msg_code <= 8'h00;
		end else if (ce) begin
			msg_code <= (ul_warning || ul_fault) ? `UL_MSG_CODE : 8'h00;
		end
	end

	// Fault state and automatic restart
	drive_sup_pkg::fault_t latched;
	logic any_fault_in;
	logic cond_ok;
	logic allowed;
	logic [TW-1:0] trial_cnt;
	logic trial_active;
	logic trial_expire;
	logic sleep_go;
	logic wake_hit;
	assign any_fault_in = |fault_in;
	assign cond_ok = (!latched.under_v || meas.dc_ok) && (!latched.over_v || meas.dc_ok)
		&& (!latched.ref_flt || meas.ref_ma >= `REF_MA_MIN)
		&& (!latched.temp_flt || (meas.temp >= `TEMP_LO && meas.temp <= `TEMP_HI));
	assign allowed = !ul_fault && (|latched)
		&& (!(latched.under_v || latched.over_v) || (latched.under_v ? rs_uv_en : 1'b1) && (latched.over_v ? rs_ov_en : 1'b1))
		&& (!latched.over_i || rs_oc_en)
		&& (!latched.ref_flt || rs_ref_en) && (!latched.temp_flt || rs_temp_en);
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			mode <= drive_sup_pkg::RUN_ST;
			latched <= '0;
			ul_fault <= 1'b0;
			restart_pulse <= 1'b0;
			restart_count <= 4'h0;
		end else if (ce) begin
			restart_pulse <= 1'b0;
			case (mode)
				drive_sup_pkg::RUN_ST: begin
					if (any_fault_in || ul_fault_set) begin
						mode <= drive_sup_pkg::FAULT_ST;
						latched <= fault_in;
						ul_fault <= ul_fault_set;
					end else if (sleep_go) begin
						mode <= drive_sup_pkg::SLEEP_ST;
					end
				end
				drive_sup_pkg::SLEEP_ST: begin
					if (any_fault_in) begin
						mode <= drive_sup_pkg::FAULT_ST;
						latched <= fault_in;
					end else if (wake_hit) begin
						mode <= drive_sup_pkg::RUN_ST;
					end
				end
				drive_sup_pkg::FAULT_ST: begin
					if (fault_reset) begin
						mode <= drive_sup_pkg::RUN_ST;
						latched <= '0;
						ul_fault <= 1'b0;
					end else if (tick && allowed && cond_ok && restart_count < restart_tries) begin
						mode <= drive_sup_pkg::RUN_ST;
						latched <= '0;
						restart_pulse <= 1'b1;
						restart_count <= restart_count + 4'h1;
					end
				end
				default: begin
					mode <= drive_sup_pkg::RUN_ST;
				end
			endcase
			if (trial_expire && mode != drive_sup_pkg::FAULT_ST) begin
				restart_count <= 4'h0;
			end
		end
	end
	// Window opens on the first restart; count clears once it lapses outside the fault state
	assign trial_expire = trial_active && tick && (trial_cnt >= trial_time);
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			trial_cnt <= '0;
			trial_active <= 1'b0;
		end else if (ce) begin
			if (restart_pulse && !trial_active) begin
				trial_active <= 1'b1;
				trial_cnt <= '0;
			end else if (trial_expire) begin
				trial_active <= 1'b0;
			end else if (trial_active && tick) begin
				trial_cnt <= trial_cnt + 1'b1;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			flying_start <= 1'b0;
		end else if (ce && restart_pulse) begin
			flying_start <= restart_flying;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			run_req <= 1'b0;
		end else if (ce) begin
			run_req <= running;
		end
	end

	// Sleep and wake
	logic [TW-1:0] sleep_cnt;
	assign sleep_go = (sleep_level != 16'h0000) && run_cmd && tick && (sleep_cnt >= sleep_dly)
		&& (meas.freq < sleep_level);
	assign wake_hit = wake_on_rise ? (ref_in > wake_level) : (ref_in < wake_level);
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sleep_cnt <= '0;
		end else if (ce && tick) begin
			if (mode == drive_sup_pkg::RUN_ST && sleep_level != 16'h0000 && meas.freq < sleep_level) begin
				if (sleep_cnt < sleep_dly) begin
					sleep_cnt <= sleep_cnt + 1'b1;
				end
			end else begin
				sleep_cnt <= '0;
			end
		end
	end

	// Staging keeps running while asleep
	logic [N_AUX-1:0] aux_start;
	genvar gi;
	for (gi = 0; gi < N_AUX; gi++) begin : g_aux
		aux_stage #(
			.DW(TW)
		) u_stage (
			.sys_clk(sys_clk),
			.rst_b(rst_b),
			.ce(ce),
			.tick(tick),
			.enable(32'(gi) < 32'(aux_count) && mode != drive_sup_pkg::FAULT_ST),
			.freq(meas.freq),
			.cfg(aux_cfg[gi]),
			.start_dly(aux_start_dly),
			.stop_dly(aux_stop_dly),
			.on(aux_relay[gi]),
			.start_pulse(aux_start[gi])
		);
	end
	assign first_relay_output = aux_relay[0];

	logic [15:0] next_ref;
	logic [15:0] next_target;
	always_comb begin
		next_ref = ref_in;
		next_target = 16'h0000;
		for (int i = 0; i < N_AUX; i++) begin
			if (aux_relay[i]) begin
				next_ref = next_ref + aux_cfg[i].ref_step;
			end
			if (aux_start[i]) begin
				next_target = aux_cfg[i].stop_f;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			active_ref <= 16'h0000;
			freq_drop_req <= 1'b0;
			freq_drop_target <= 16'h0000;
		end else if (ce) begin
			active_ref <= next_ref;
			freq_drop_req <= |aux_start;
			if (|aux_start) begin
				freq_drop_target <= next_target;
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/drive_supervisor_asserts.sv
// Port-level checker for the drive supervisor, bound into every instance.
// Assumes all ports belong to the sys_clk domain and rst_b is synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "drive_sup_map.svh"
module drive_supervisor_asserts #(
	parameter int N_AUX = 3
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic tick,
	input wire logic stall_cur_over,
	input wire drive_sup_pkg::meas_t meas,
	input wire logic [15:0] stall_freq_max,
	input wire logic [15:0] freq_max,
	input wire logic [15:0] field_weak_freq,
	input wire logic [1:0] ul_resp,
	input wire logic [15:0] ul_fw_load,
	input wire logic motor_cur_changed,
	input wire logic [3:0] restart_tries,
	input wire drive_sup_pkg::aux_cfg_t [N_AUX-1:0] aux_cfg,
	input wire logic [15:0] sleep_level,
	input wire logic stall_freq_ok,
	input wire logic [15:0] ul_min_torque,
	input wire logic [15:0] ul_counter,
	input wire logic ul_fault,
	input wire logic restart_pulse,
	input wire logic [3:0] restart_count,
	input wire logic [N_AUX-1:0] aux_relay,
	input wire logic freq_drop_req,
	input wire logic [15:0] freq_drop_target,
	input wire drive_sup_pkg::mode_t mode
);
	logic [15:0] stall_lim;
	logic [15:0] fw_cl;
	// Stall limit can never sit above the maximum frequency
	assign stall_lim = (stall_freq_max > freq_max) ? freq_max : stall_freq_max;
	assign fw_cl = (ul_fw_load < `UL_FW_MIN) ? `UL_FW_MIN : (ul_fw_load > `UL_FW_MAX) ? `UL_FW_MAX : ul_fw_load;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	AST_STALL_FREQ: assert property (ce && tick |=>
		stall_freq_ok == ($past(stall_cur_over) && $past(meas.freq) < $past(stall_lim)))
		else $error("stall frequency flag wrong");
	AST_UL_HOLD: assert property (ce && meas.freq < `FREQ_UL_MIN |=> ul_counter == $past(ul_counter) || ul_counter == 16'h0000)
		else $error("underload counter moved at low frequency");
	AST_UL_OFF: assert property (ce && ul_resp == `RESP_OFF |=> ul_counter == 16'h0000)
		else $error("underload counter not cleared when off");
	// Load setting lags its input by one clock and the current-change default by two
	AST_UL_FW: assert property (ce && tick && meas.freq > field_weak_freq && !$past(motor_cur_changed)
		&& !$past(motor_cur_changed, 2) && $stable(ul_fw_load) |=> ul_min_torque == $past(fw_cl))
		else $error("minimum torque above field weakening wrong");
	AST_UL_STOP: assert property ($rose(ul_fault) |-> ##[0:2] mode == drive_sup_pkg::FAULT_ST)
		else $error("underload fault did not stop the drive");
	AST_RS_LIMIT: assert property (restart_pulse |-> restart_count <= restart_tries && !$past(restart_pulse))
		else $error("restart beyond allowed count");
	AST_AUX_DROP: assert property ($rose(aux_relay[0]) |=> freq_drop_req && freq_drop_target == aux_cfg[0].stop_f)
		else $error("no frequency drop after auxiliary start");
	AST_AUX_ON: assert property ($rose(aux_relay[0]) |-> $past(meas.freq) >= aux_cfg[0].start_f + `FREQ_HYST)
		else $error("auxiliary started without hysteresis margin");
	AST_SLEEP: assert property (mode == drive_sup_pkg::SLEEP_ST && $past(mode) != drive_sup_pkg::SLEEP_ST |-> $past(sleep_level) != 16'h0000)
		else $error("sleep entered while sleep disabled");
	cover property ($rose(ul_fault));
	cover property (restart_pulse);
	cover property ($rose(aux_relay[0]));
endmodule
bind drive_supervisor drive_supervisor_asserts #(.N_AUX(N_AUX)) chk (.*);
`default_nettype wire

// ===== tb/motor_model.sv
// Behavioural motor and pump set seen by the supervisor's measurement input.
// Assumes the bench chooses speed, load and which sensor reads out of range.
`timescale 1ns/1ps
`default_nettype none
module motor_model (
	input wire logic sys_clk,
	input wire logic run_req,
	input wire logic [2:0] sensor_bad,
	input wire logic [15:0] set_freq,
	input wire logic [15:0] set_torque,
	output drive_sup_pkg::meas_t meas
);
	logic [2:0] bad;
	// Sensors settle one clock after the bench disturbs them
	always_ff @(posedge sys_clk) begin
		bad <= sensor_bad;
	end
	// A stopped drive reports zero speed, never the last running value
	always_comb begin
		meas.freq = run_req ? set_freq : 16'h0000;
		meas.torque = set_torque;
		meas.dc_ok = !bad[0];
		meas.ref_ma = bad[1] ? 16'h018F : 16'h07D0;
		meas.temp = bad[2] ? 16'sh004C : 16'sh0019;
	end
endmodule
`default_nettype wire

// ===== tb/tb_drive_supervisor.sv
// Self-checking bench for the drive supervisor with a motor model.
// Assumes one tick every four sys_clk cycles and times counted in ticks.
`timescale 1ns/1ps
`default_nettype none
module tb_drive_supervisor;
	logic sys_clk = 1'h0, rst_b = 1'h0, ce = 1'h1, tick = 1'h0, run_cmd_pin = 1'h0, stall_cur_over = 1'h1;
	logic motor_cur_changed = 1'h0, restart_flying = 1'h0, rs_uv_en = 1'h1, rs_ov_en = 1'h1, rs_oc_en = 1'h1;
	logic rs_ref_en = 1'h1, rs_temp_en = 1'h1, fault_reset = 1'h0, wake_on_rise = 1'h1;
	logic [15:0] stall_freq_max = 16'h07D0, freq_max = 16'h1388, field_weak_freq = 16'h09C4, ul_fw_load = 16'h0032;
	logic [15:0] ul_zf_load = 16'h0064, ul_time = 16'h0014, trial_time = 16'h0005, aux_start_dly = 16'h0002;
	logic [15:0] aux_stop_dly = 16'h0002, ref_in = 16'h0100, sleep_level = 16'h0000, sleep_dly = 16'h0003;
	logic [15:0] wake_level = 16'h1000, set_freq = 16'h0000, set_torque = 16'h0000;
	logic [1:0] ul_resp = 2'h1, aux_count = 2'h1, ph = 2'h0;
	logic [3:0] restart_tries = 4'h1;
	logic [2:0] sensor_bad = 3'h0;
	drive_sup_pkg::fault_t fault_in = 5'h00;
	drive_sup_pkg::aux_cfg_t [2:0] aux_cfg = {3{48'h0BB8_07D0_0032}};
	drive_sup_pkg::meas_t meas;
	logic stall_freq_ok, ul_warning, ul_fault, run_req, flying_start, restart_pulse, first_relay_output, freq_drop_req;
	logic [15:0] ul_min_torque, ul_counter, freq_drop_target, active_ref;
	logic [7:0] msg_code;
	logic [2:0] aux_relay;
	logic [3:0] restart_count;
	drive_sup_pkg::mode_t mode;
	int err_total = 0, n_checks = 0;
	drive_supervisor uut (.*);
	motor_model partner (.sys_clk(sys_clk), .run_req(run_req), .sensor_bad(sensor_bad), .set_freq(set_freq),
		.set_torque(set_torque), .meas(meas));
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		ph <= ph + 2'h1;
		tick <= #1 (ph == 2'h2);
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tk(input int n);
		repeat (n * 4) @(posedge sys_clk);
		#1;
	endtask
	task automatic pulse_flt(input drive_sup_pkg::fault_t f);
		fault_in = f;
		@(posedge sys_clk);
		#1;
		fault_in = 5'h00;
	endtask
	task automatic clr_flt;
		fault_reset = 1'h1;
		tk(1);
		fault_reset = 1'h0;
	endtask
	task automatic end_sim;
		if (err_total == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		end_sim;
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		#1;
		rst_b = 1'h1;
		tk(1);
		chk(ul_min_torque, 16'h0064);
		run_cmd_pin = 1'h1;
		set_freq = 16'h07CF;
		tk(1);
		chk(16'(stall_freq_ok), 16'h0001);
		set_freq = 16'h07D0;
		tk(1);
		chk(16'(stall_freq_ok), 16'h0000);
		set_freq = 16'h04E2;
		tk(1);
		chk(ul_min_torque, 16'h007D);
		set_freq = 16'h0BB8;
		tk(25);
		chk(ul_min_torque, 16'h00C8);
		chk(16'(ul_warning), 16'h0001);
		chk(16'(msg_code), 16'h0011);
		motor_cur_changed = 1'h1;
		tk(1);
		chk(ul_min_torque, 16'h0320);
		motor_cur_changed = 1'h0;
		ul_resp = 2'h0;
		tk(1);
		chk(ul_counter, 16'h0000);
		ul_resp = 2'h1;
		set_freq = 16'h01F3;
		tk(5);
		chk(ul_counter, 16'h0000);
		ul_resp = 2'h2;
		set_freq = 16'h0BB8;
		tk(25);
		chk(16'(ul_fault), 16'h0001);
		chk(16'(msg_code), 16'h0011);
		tk(2);
		chk(16'(mode), 16'h0003);
		chk(ul_counter, 16'h0000);
		ul_resp = 2'h0;
		clr_flt;
		pulse_flt(5'h04);
		tk(2);
		chk(16'(restart_count), 16'h0001);
		chk(16'(mode), 16'h0000);
		chk(16'(flying_start), 16'h0000);
		pulse_flt(5'h04);
		tk(2);
		chk(16'(mode), 16'h0003);
		clr_flt;
		tk(8);
		chk(16'(restart_count), 16'h0000);
		rs_oc_en = 1'h0;
		pulse_flt(5'h04);
		tk(3);
		chk(16'(mode), 16'h0003);
		clr_flt;
		rs_oc_en = 1'h1;
		set_freq = 16'h0C1B;
		tk(5);
		chk(16'(aux_relay), 16'h0000);
		set_freq = 16'h0C1D;
		tk(1);
		chk(16'(aux_relay), 16'h0000);
		tk(4);
		chk(16'(aux_relay), 16'h0001);
		chk(16'(first_relay_output), 16'h0001);
		chk(freq_drop_target, 16'h07D0);
		chk(active_ref, 16'h0132);
		set_freq = 16'h076B;
		tk(5);
		chk(16'(aux_relay), 16'h0000);
		sleep_level = 16'h03E8;
		set_freq = 16'h01F4;
		tk(6);
		chk(16'(mode), 16'h0001);
		chk(16'(run_req), 16'h0000);
		ref_in = 16'h1100;
		tk(2);
		chk(16'(mode), 16'h0000);
		chk(16'(run_req), 16'h0001);
		sleep_level = 16'h0000;
		restart_tries = 4'h3;
		restart_flying = 1'h1;
		sensor_bad = 3'h1;
		pulse_flt(5'h13);
		tk(3);
		chk(16'(mode), 16'h0003);
		sensor_bad = 3'h0;
		tk(2);
		chk(16'(mode), 16'h0000);
		chk(16'(flying_start), 16'h0001);
		sensor_bad = 3'h2;
		pulse_flt(5'h13);
		tk(3);
		chk(16'(mode), 16'h0003);
		sensor_bad = 3'h0;
		tk(2);
		chk(16'(mode), 16'h0000);
		sensor_bad = 3'h4;
		pulse_flt(5'h13);
		tk(3);
		chk(16'(mode), 16'h0003);
		sensor_bad = 3'h0;
		tk(2);
		chk(16'(mode), 16'h0000);
		end_sim;
	end
endmodule
`default_nettype wire
